// ===== bgc_defs.vh
// Constants for the bridge general control register, upper field group (bits 31:20).
// Assumes a configuration-space access port supplying dword index and byte enables.
`ifndef BGC_DEFS_VH
`define BGC_DEFS_VH
`define BGC_OFFSET 8'hD4
`define BGC_RETRY_LO 30
`define BGC_LOWSWING_BIT 27
`define BGC_PMREV_BIT 26
`define BGC_STRICT_BIT 25
`define BGC_MULTILINE_BIT 24
`define BGC_LINKPM_BIT 23
`define BGC_SHORT_LO 20
`define BGC_RST_RETRY 2'h2
`define BGC_RST_UPPER 12'h820
`define BGC_CLK_MHZ 250
`define BGC_T0_US 25
`define BGC_T1_US 1000
`define BGC_T2_US 25000
`define BGC_T3_US 50000
`define BGC_ACT_IGNORE 3'h0
`define BGC_ACT_PIN 3'h1
`define BGC_ACT_CLK 3'h2
`define BGC_ACT_BOTH 3'h3
`define BGC_ACT_UR 3'h4
`define BGC_PMREV_OLD 3'h2
`define BGC_PMREV_NEW 3'h3
`endif

// ===== bgc_retry_timer.v
// Configuration retry window timer for the secondary bus.
// Assumes retry and completion strobes come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "bgc_defs.vh"
module bgc_retry_timer #(
	parameter [31:0] CYC0 = `BGC_T0_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC1 = `BGC_T1_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC2 = `BGC_T2_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC3 = `BGC_T3_US * `BGC_CLK_MHZ
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [1:0] config_retry_window,
	input wire sec_retry,
	input wire req_done,
	output reg window_expired
);
	reg [31:0] cnt_r;
	reg run_r;
	reg [31:0] limit;
	always @* begin
		case (config_retry_window)
		2'h0: limit = CYC0;
		2'h1: limit = CYC1;
		2'h2: limit = CYC2;
		default: limit = CYC3;
		endcase
	end
	always @(posedge core_clk) begin
		if (sys_rst || req_done) begin
			cnt_r <= 32'h0000_0000;
			run_r <= 1'b0;
			window_expired <= 1'b0;
		end else begin
			if (sec_retry)
				run_r <= 1'b1;
			if ((run_r || sec_retry) && !window_expired) begin
				cnt_r <= cnt_r + 32'h0000_0001;
				// Saturating: stays expired until the request completes.
				// Expires only once a full window has passed since the first retry.
				if (cnt_r >= limit)
					window_expired <= 1'b1;
			end
		end
	end
endmodule // bgc_retry_timer
`default_nettype wire

// ===== bgc_general_control.v
// Upper field group of the bridge general control register and its effects.
// Drives the field effects (retry window, transmit swing, revision, arbitration,
// prefetch, link power default, power shortfall actions) to the rest of the bridge.
// Assumes a simple configuration port: dword index, byte enables, write strobe.
`timescale 1ns/1ps
`default_nettype none
`include "bgc_defs.vh"
module bgc_general_control #(
	parameter [31:0] CYC0 = `BGC_T0_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC1 = `BGC_T1_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC2 = `BGC_T2_US * `BGC_CLK_MHZ,
	parameter [31:0] CYC3 = `BGC_T3_US * `BGC_CLK_MHZ,
	parameter CLK_W = 7
) (
	input wire core_clk,
	input wire sys_rst,
	input wire link_fund_rst,
	input wire global_reset_pin,
	input wire por_rst,
	input wire [7:0] cfg_addr,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	input wire sec_retry,
	input wire req_done,
	output wire cfg_retry_ok,
	output wire tx_low_swing,
	output wire [2:0] pm_revision_field,
	output wire pm_state_preserved,
	input wire [2:0] low_prio_count,
	output wire [2:0] low_prio_count_default,
	output wire strict_vc_priority,
	output wire force_multiline_read,
	output wire [1:0] link_pm_control_field,
	input wire power_shortfall,
	output reg power_shortfall_pin,
	input wire [CLK_W-1:0] clock_mask,
	output reg [CLK_W-1:0] sec_clk_stop,
	input wire [2:0] txn_kind,
	output wire unsupported_request
);
	// Transaction kinds that stay legal while slot power is short;
	// any other code, reserved ones included, counts as an ordinary request
	localparam [2:0] KIND_CFG0 = 3'h1;
	localparam [2:0] KIND_CFG1 = 3'h2;
	localparam [2:0] KIND_SLOT_PWR = 3'h3;
	// Power-up image of bits 31:20
	localparam [11:0] RST_UPPER = `BGC_RST_UPPER;

	// Two stages on the asynchronous global reset pin
	reg gr_s1_r;
	reg gr_s2_r;

	// Writable fields and their next values
	reg [1:0] retry_r;
	reg [1:0] retry_nxt;
	reg lowswing_r;
	reg lowswing_nxt;
	reg pmrev_r;
	reg pmrev_nxt;
	reg strict_r;
	reg strict_nxt;
	reg mlread_r;
	reg mlread_nxt;
	reg linkpm_r;
	reg linkpm_nxt;
	reg [2:0] short_r;
	reg [2:0] short_nxt;
	reg [31:0] rdata_nxt;

	// Decode and effect nets
	wire any_rst;
	wire hit;
	wire wr_hi;
	wire wr_mid;
	wire [31:0] upper_word;
	wire [2:0] short_act;
	wire act_pin;
	wire act_clk;
	wire act_ur;
	wire kind_exempt;
	wire pin_nxt;
	wire [CLK_W-1:0] clk_stop_nxt;

	// Only the second stage is read, so a metastable first stage never reaches logic
	always @(posedge core_clk) begin
		gr_s1_r <= global_reset_pin;
		gr_s2_r <= gr_s1_r;
	end

	// Every reset source returns the writable fields to their defaults
	assign any_rst = sys_rst | link_fund_rst | gr_s2_r | por_rst;
	assign hit = (cfg_addr == `BGC_OFFSET);
	assign wr_hi = cfg_wr && hit && cfg_be[3];
	assign wr_mid = cfg_wr && hit && cfg_be[2];

	// Next values: a byte enable picks which fields a write touches
	always @* begin
		retry_nxt = retry_r;
		lowswing_nxt = lowswing_r;
		pmrev_nxt = pmrev_r;
		strict_nxt = strict_r;
		mlread_nxt = mlread_r;
		linkpm_nxt = linkpm_r;
		short_nxt = short_r;
		// Byte 3 holds bits 31:24; bits 29:28 have no storage behind them
		if (wr_hi) begin
			retry_nxt = cfg_wdata[`BGC_RETRY_LO+1:`BGC_RETRY_LO];
			lowswing_nxt = cfg_wdata[`BGC_LOWSWING_BIT];
			pmrev_nxt = cfg_wdata[`BGC_PMREV_BIT];
			strict_nxt = cfg_wdata[`BGC_STRICT_BIT];
			mlread_nxt = cfg_wdata[`BGC_MULTILINE_BIT];
		end
		// Byte 2 holds bits 23:16; bits 19:16 are the lower half's business
		if (wr_mid) begin
			linkpm_nxt = cfg_wdata[`BGC_LINKPM_BIT];
			short_nxt = cfg_wdata[`BGC_SHORT_LO+2:`BGC_SHORT_LO];
		end
	end

	// Reset wins over a write landing in the same cycle
	always @(posedge core_clk) begin
		if (any_rst) begin
			retry_r <= `BGC_RST_RETRY;
			lowswing_r <= RST_UPPER[7];
			pmrev_r <= RST_UPPER[6];
			strict_r <= RST_UPPER[5];
			mlread_r <= RST_UPPER[4];
			linkpm_r <= RST_UPPER[3];
			short_r <= `BGC_ACT_IGNORE;
		end else begin
			retry_r <= retry_nxt;
			lowswing_r <= lowswing_nxt;
			pmrev_r <= pmrev_nxt;
			strict_r <= strict_nxt;
			mlread_r <= mlread_nxt;
			linkpm_r <= linkpm_nxt;
			short_r <= short_nxt;
		end
	end

	// Bits 29:28 are hardwired zero; 19:0 belong to the lower half
	assign upper_word = {retry_r, 2'h0, lowswing_r, pmrev_r, strict_r, mlread_r,
		linkpm_r, short_r, 20'h0_0000};

	// A miss or an idle cycle reads as zero, so stale data never lingers on the bus
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (cfg_rd && hit)
			rdata_nxt = upper_word;
	end

	always @(posedge core_clk) begin
		if (any_rst)
			cfg_rdata <= 32'h0000_0000;
		else
			cfg_rdata <= rdata_nxt;
	end

	// The window counter sees the same combined reset as the fields;
	// cfg_retry_ok stays high until the request completes
	bgc_retry_timer #(
		.CYC0(CYC0),
		.CYC1(CYC1),
		.CYC2(CYC2),
		.CYC3(CYC3)
	) u_timer (
		.core_clk(core_clk),
		.sys_rst(any_rst),
		.config_retry_window(retry_r),
		.sec_retry(sec_retry),
		.req_done(req_done),
		.window_expired(cfg_retry_ok)
	);

	// Field effects are plain wires from the stored bits
	assign tx_low_swing = lowswing_r;
	assign pm_revision_field = pmrev_r ? `BGC_PMREV_NEW : `BGC_PMREV_OLD;
	assign pm_state_preserved = pmrev_r;
	// The arbiter loads this count at its own reset, so it tracks bit 25 live
	assign low_prio_count_default = strict_r ? 3'h0 : 3'h1;
	assign strict_vc_priority = strict_r && (low_prio_count == 3'h0);
	assign force_multiline_read = mlread_r;
	// The link control logic loads this default at power-up
	assign link_pm_control_field = linkpm_r ? 2'h3 : 2'h0;

	// Reserved codes fall through to ignore; software must not use them
	assign short_act = (short_r > `BGC_ACT_UR) ? `BGC_ACT_IGNORE : short_r;
	assign act_pin = (short_act == `BGC_ACT_PIN) || (short_act == `BGC_ACT_BOTH);
	assign act_clk = (short_act == `BGC_ACT_CLK) || (short_act == `BGC_ACT_BOTH);
	assign act_ur = (short_act == `BGC_ACT_UR);
	assign pin_nxt = power_shortfall && act_pin;

	// One gate per secondary clock; unmasked clocks keep running
	genvar gi;
	generate
		for (gi = 0; gi < CLK_W; gi = gi + 1) begin : g_clk_stop
			assign clk_stop_nxt[gi] = power_shortfall && act_clk && clock_mask[gi];
		end
	endgenerate

	// Registered so that a glitch on the shortfall level never reaches a pin
	always @(posedge core_clk) begin
		if (any_rst) begin
			power_shortfall_pin <= 1'h0;
			sec_clk_stop <= {CLK_W{1'h0}};
		end else begin
			power_shortfall_pin <= pin_nxt;
			sec_clk_stop <= clk_stop_nxt;
		end
	end

	// Configuration requests and slot power messages keep working, so software
	// can still read status and raise the limit while power is short
	assign kind_exempt = (txn_kind == KIND_CFG0) || (txn_kind == KIND_CFG1) ||
		(txn_kind == KIND_SLOT_PWR);
	// Combinational, so the decision is ready in the cycle the request is decoded
	assign unsupported_request = power_shortfall && act_ur && !kind_exempt;
endmodule // bgc_general_control
`default_nettype wire

// ===== bgc_gc_props.sv
// Checker for the general control upper fields.
// Bound to bgc_general_control; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module bgc_gc_props #(parameter CLK_W = 7) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cfg_rd,
	input wire logic pm_state_preserved,
	input wire logic strict_vc_priority,
	input wire logic power_shortfall,
	input wire logic power_shortfall_pin,
	input wire logic unsupported_request,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	input wire logic [2:0] pm_revision_field,
	input wire logic [2:0] low_prio_count,
	input wire logic [2:0] low_prio_count_default,
	input wire logic [2:0] txn_kind,
	input wire logic [1:0] link_pm_control_field,
	input wire logic [CLK_W-1:0] clock_mask,
	input wire logic [CLK_W-1:0] sec_clk_stop
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	rsv_read_a: assert property (cfg_rdata[29:28] == 2'h0) else $error("rsv");
	// Reset itself is the cause here, so the default disable is overridden
	rst_clear_a: assert property (disable iff (1'b0) sys_rst |=> cfg_rdata == 0)
		else $error("rst");
	miss_zero_a: assert property (cfg_rd && cfg_addr != 8'hD4 |=> cfg_rdata == 0)
		else $error("miss");
	pm_rev_a: assert property (pm_revision_field == 3'h2 + pm_state_preserved)
		else $error("rev");
	strict_vc_a: assert property (strict_vc_priority ==
		(low_prio_count == 0 && low_prio_count_default == 0)) else $error("vc");
	count_def_a: assert property (low_prio_count_default[2:1] == 2'h0)
		else $error("cnt");
	link_pm_a: assert property (link_pm_control_field[1] == link_pm_control_field[0])
		else $error("lpm");
	ur_kind_a: assert property (unsupported_request |-> !(txn_kind inside {1, 2, 3}))
		else $error("ur");
	pin_cause_a: assert property ($rose(power_shortfall_pin) |-> $past(power_shortfall))
		else $error("pin");
	clk_mask_a: assert property ((sec_clk_stop & ~$past(clock_mask)) == 0)
		else $error("clk");
	rst_default_a: assert property (disable iff (1'b0) sys_rst |=>
		pm_revision_field == 3'h2 && low_prio_count_default == 3'h0 &&
		link_pm_control_field == 2'h0) else $error("rst dflt");
	cover property (power_shortfall_pin);
	cover property (unsupported_request);
	cover property (strict_vc_priority);
endmodule // bgc_gc_props
bind bgc_general_control bgc_gc_props #(.CLK_W(CLK_W)) u_props (.*);
`default_nettype wire

// ===== bgc_general_control_tb.sv
// Bench for the general control upper fields.
// Assumes retry periods shortened to 10, 20, 30 and 40 cycles.
`timescale 1ns/1ps
`default_nettype none
module bgc_general_control_tb;
	logic core_clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, sec_retry = 0, req_done = 0;
	logic power_shortfall = 0, link_fund_rst = 0, por_rst = 0, global_reset_pin = 0, pend = 0;
	logic cfg_retry_ok, tx_low_swing, pm_state_preserved, strict_vc_priority;
	logic force_multiline_read, power_shortfall_pin, unsupported_request;
	logic [2:0] low_prio_count = 0, txn_kind = 0, pm_revision_field, low_prio_count_default;
	logic [3:0] cfg_be = 0;
	logic [7:0] cfg_addr = 0;
	logic [6:0] clock_mask = 0, sec_clk_stop;
	logic [1:0] link_pm_control_field;
	logic [11:0] m = 12'h820;
	logic [31:0] cfg_wdata = 0, cfg_rdata, q[$];
	int fail_count = 0, checks = 0, cyc = 0, n;
	bgc_general_control #(.CYC0(10), .CYC1(20), .CYC2(30), .CYC3(40)) u_dut (.*);
	initial forever #2 core_clk = ~core_clk;
	task chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checks %0d fails %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Read data lives one cycle, so it is compared at the following low phase
	always @(posedge core_clk) begin
		pend <= cfg_rd;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			close_out;
		end
	end
	always @(negedge core_clk) if (pend) chk(cfg_rdata, q.pop_front());
	task wm(input logic [31:0] v, input logic [3:0] b);
		if (v[22]) v[21:20] = 2'h0;
		@(posedge core_clk);
		cfg_addr <= 8'hD4;
		cfg_wr <= 1;
		cfg_be <= b;
		cfg_wdata <= v;
		if (b[3]) m[11:4] = v[31:24] & 8'hCF;
		if (b[2]) m[3:0] = v[23:20];
		@(posedge core_clk);
		cfg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		cfg_addr <= a;
		cfg_rd <= 1;
		q.push_back(e);
		@(posedge core_clk);
		cfg_rd <= 0;
	endtask
	task outs;
		#1;
		chk(tx_low_swing, m[7]);
		chk(pm_revision_field, m[6] ? 3'h3 : 3'h2);
		chk(pm_state_preserved, m[6]);
		chk(low_prio_count_default, m[5] ? 3'h0 : 3'h1);
		chk(strict_vc_priority, m[5] && low_prio_count == 0);
		chk(force_multiline_read, m[4]);
		chk(link_pm_control_field, {2{m[3]}});
		rd(8'hD4, {m, 20'h0});
	endtask
	initial begin
		void'($urandom(97960));
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		outs;
		rd(8'hD0, 0);
		repeat (6) begin
			low_prio_count <= 3'($urandom % 2);
			wm($urandom, 4'($urandom));
			outs;
		end
		$display("field test done");
		power_shortfall <= 1;
		for (int c = 0; c < 5; c++) begin
			wm(32'(c) << 20, 4'h4);
			repeat (2) @(posedge core_clk);
			#1;
			chk(power_shortfall_pin, c == 1 || c == 3);
			chk(sec_clk_stop, (c == 2 || c == 3) ? clock_mask : 7'h0);
			for (int k = 0; k < 8; k++) begin
				@(posedge core_clk);
				txn_kind <= 3'(k);
				clock_mask <= 7'($urandom);
				#1;
				chk(unsupported_request, c == 4 && (k == 0 || k > 3));
			end
		end
		@(posedge core_clk);
		power_shortfall <= 0;
		$display("shortfall test done");
		for (int s = 0; s < 4; s++) begin
			wm(32'(s) << 30, 4'h8);
			sec_retry <= 1;
			@(posedge core_clk);
			sec_retry <= 0;
			n = 0;
			while (cfg_retry_ok !== 1 && n < 99) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			chk(n, 10 * (s + 1));
			@(posedge core_clk);
			req_done <= 1;
			@(posedge core_clk);
			req_done <= 0;
			@(posedge core_clk);
			#1;
			chk(cfg_retry_ok, 0);
		end
		$display("retry test done");
		for (int i = 0; i < 3; i++) begin
			wm($urandom, 4'hC);
			{global_reset_pin, por_rst, link_fund_rst} <= 3'(1 << i);
			repeat (3) @(posedge core_clk);
			{global_reset_pin, por_rst, link_fund_rst} <= 3'h0;
			repeat (3) @(posedge core_clk);
			m = 12'h820;
			outs;
		end
		$display("reset source test done");
		close_out;
	end
endmodule // bgc_general_control_tb
`default_nettype wire
